// ### pmc_control_regs.sv
// transceiver management register set with basic control behaviour
//
// Overview of operation
// [R01] decode 16-bit registers at indices 0-6, 17, 18, 27, 29, 30, 31
// [R02] registers reached only by index through the management access port
// [R03] kept fields survive only the control-bit-15 soft reset
// [R04] writing bit 15 starts soft reset; bit self-clears, reads 0 after reset
// [R05] master should set bit 15 with all other control bits clear
// [R06] bit 14 selects loopback; resets to 0
// [R07] bit 13 selects 100 or 10 Mbps; ignored while negotiation enabled
// [R08] bit 12 enables negotiation, overriding manual speed and duplex
// [R09] speed and negotiation-enable reset values come from the strap pin
// [R10] bit 11 selects general power-down; resets to 0
// [R11] after power-down clears, negotiation runs and then sets status bit 5
// [R12] writing bit 9 restarts negotiation; bit self-clears
// [R13] bit 8 selects full duplex; resets 0; ignored while negotiating
// [R14] bit 7 enables collision test; resets to 0
// [R15] status bit 5 reads 1 once negotiation completed, else 0
// [R16] control bits 10 and 6-0 read zero; writes ignored
`timescale 1ns/100ps
module pmc_control_regs #(
    parameter int ANEG_CYCLES = pmc_pkg::ANEG_CYCLES_DEFAULT,
    // identity values are arbitrary
    parameter logic [15:0] IDENT_HIGH = 16'h1234,
    parameter logic [15:0] IDENT_LOW = 16'h5678
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire pmc_pkg::pmc_mgmt_req_t mgmt_req,
    output pmc_pkg::pmc_mgmt_rsp_t mgmt_rsp,
    input wire logic speed_sel_pin,
    input wire logic link_up_pin,
    output pmc_pkg::pmc_mode_t mode
);
    logic strap_sync;
    logic link_sync;
    logic sync_settled;
    logic strap_pending;
    logic [pmc_pkg::SOFT_CNT_W-1:0] soft_cnt;
    logic soft_busy;
    logic soft_start;
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [15:0] strap_ctrl;
    logic [15:0] adv;
    logic [15:0] strap_adv;
    logic link_latched;
    logic aneg_done;
    logic aneg_speed;
    logic aneg_full;
    logic [15:0] gen_reg [pmc_pkg::GEN_COUNT];
    logic [pmc_pkg::GEN_COUNT-1:0] gen_hit;
    logic [15:0] gen_rdata;
    logic wr_ctrl;
    logic wr_adv;
    logic rd_status;
    logic idx_mapped;
    logic defaults_load;
    logic [15:0] read_value;

    pmc_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in({speed_sel_pin, link_up_pin}),
        .pin_out({strap_sync, link_sync}),
        .settled(sync_settled)
    );

    pmc_aneg_sequencer #(
        .ANEG_CYCLES(ANEG_CYCLES)
    ) u_aneg (
        .sys_clk(sys_clk),
        .reset(reset),
        .enable(ctrl[pmc_pkg::CTL_ANEG_EN]),
        .power_down(ctrl[pmc_pkg::CTL_POWER_DOWN]),
        .restart(ctrl[pmc_pkg::CTL_ANEG_RESTART] || soft_busy), // R11 R12
        .advertise(adv),
        .complete(aneg_done),
        .res_speed_100(aneg_speed),
        .res_full_duplex(aneg_full)
    );

    // access decode, index only
    assign wr_ctrl = mgmt_req.wr && mgmt_req.index == pmc_pkg::IDX_BASIC_CONTROL; // R02
    assign wr_adv = mgmt_req.wr && mgmt_req.index == pmc_pkg::IDX_NEG_ADVERTISE;
    assign rd_status = mgmt_req.rd && mgmt_req.index == pmc_pkg::IDX_BASIC_STATUS;
    assign soft_start = wr_ctrl && mgmt_req.wdata[pmc_pkg::CTL_SOFT_RESET] && !soft_busy; // R04
    assign soft_busy = (soft_cnt != '0);
    assign defaults_load = strap_pending || soft_start || soft_busy;
    assign strap_ctrl = pmc_pkg::CTL_RESET_VALUE | ({16{strap_sync}} & pmc_pkg::CTL_STRAP_MASK); // R09
    assign strap_adv = pmc_pkg::ADV_RESET_BASE | ({16{strap_sync}} & pmc_pkg::ADV_STRAP_BITS);

    // strap is taken once the synchroniser has settled after reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strap_pending <= 1'b1;
        end else if (sync_settled) begin
            strap_pending <= 1'b0; // R09
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            soft_cnt <= '0;
        end else if (soft_start) begin
            soft_cnt <= pmc_pkg::SOFT_CNT_W'(pmc_pkg::SOFT_RESET_CYCLES); // R04
        end else if (soft_busy) begin
            soft_cnt <= soft_cnt - pmc_pkg::SOFT_CNT_W'(1);
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        next_ctrl[pmc_pkg::CTL_ANEG_RESTART] = 1'b0; // R12
        if (defaults_load) begin
            next_ctrl = strap_ctrl; // R03 R09
        end else if (wr_ctrl) begin
            next_ctrl = mgmt_req.wdata & pmc_pkg::CTL_WRITE_MASK; // R06 R07 R08 R10 R13 R14 R16
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= pmc_pkg::CTL_RESET_VALUE;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            adv <= pmc_pkg::ADV_RESET_BASE;
        end else if (defaults_load) begin
            adv <= strap_adv;
        end else if (wr_adv) begin
            adv <= mgmt_req.wdata & pmc_pkg::ADV_WRITE_MASK;
        end
    end

    // link status latches low; a status read reloads it, a drop wins
    always_ff @(posedge sys_clk) begin
        if (reset || !link_sync) begin
            link_latched <= 1'b0;
        end else if (rd_status) begin
            link_latched <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < pmc_pkg::GEN_COUNT; g++) begin : g_gen
            assign gen_hit[g] = (mgmt_req.index == pmc_pkg::GEN_INDEX[g]);
            always_ff @(posedge sys_clk) begin
                if (reset || (soft_busy && !pmc_pkg::GEN_KEPT[g])) begin
                    gen_reg[g] <= pmc_pkg::GEN_RESET_VALUE; // R03
                end else if (mgmt_req.wr && gen_hit[g] && !soft_busy) begin
                    gen_reg[g] <= mgmt_req.wdata;
                end
            end
        end
    endgenerate

    always_comb begin
        gen_rdata = 16'h0000;
        for (int k = 0; k < pmc_pkg::GEN_COUNT; k++) begin
            gen_rdata = gen_rdata | (gen_hit[k] ? gen_reg[k] : 16'h0000);
        end
    end

    assign idx_mapped = (mgmt_req.index <= pmc_pkg::IDX_NEG_EXPANSION)
        || (|gen_hit) || mgmt_req.index == pmc_pkg::IDX_INT_SOURCE; // R01

    assign read_value =
        (mgmt_req.index == pmc_pkg::IDX_BASIC_CONTROL) ?
            ((ctrl | (16'(soft_busy) << pmc_pkg::CTL_SOFT_RESET)) & pmc_pkg::CTL_READ_MASK) :
        (mgmt_req.index == pmc_pkg::IDX_BASIC_STATUS) ?
            (pmc_pkg::STS_FIXED | (16'(aneg_done) << pmc_pkg::STS_ANEG_DONE)
                | (16'(link_latched) << pmc_pkg::STS_LINK)) : // R15
        (mgmt_req.index == pmc_pkg::IDX_IDENT_HIGH) ? IDENT_HIGH :
        (mgmt_req.index == pmc_pkg::IDX_IDENT_LOW) ? IDENT_LOW :
        (mgmt_req.index == pmc_pkg::IDX_NEG_ADVERTISE) ? adv :
        gen_rdata; // R01

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mgmt_rsp <= '0;
        end else begin
            mgmt_rsp.ack <= mgmt_req.wr || mgmt_req.rd;
            mgmt_rsp.rdata <= (mgmt_req.rd && idx_mapped) ? read_value : 16'h0000;
        end
    end

    // negotiation overrides the manual speed and duplex selections
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode <= '0;
        end else begin
            mode.loopback <= ctrl[pmc_pkg::CTL_LOOPBACK]; // R06
            mode.power_down <= ctrl[pmc_pkg::CTL_POWER_DOWN]; // R10
            mode.speed_100 <= ctrl[pmc_pkg::CTL_ANEG_EN] ? aneg_speed
                : ctrl[pmc_pkg::CTL_SPEED]; // R07 R08
            mode.full_duplex <= ctrl[pmc_pkg::CTL_ANEG_EN] ? aneg_full
                : ctrl[pmc_pkg::CTL_DUPLEX]; // R08 R13
            mode.collision_test <= ctrl[pmc_pkg::CTL_COL_TEST]; // R14
            mode.soft_reset_busy <= soft_busy;
            mode.aneg_complete <= aneg_done; // R11
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_soft_reset_length;
        $rose(soft_busy) |-> soft_busy [*8] ##12 soft_busy ##1 !soft_busy;
    endproperty
    a_soft_reset_length: assert property (p_soft_reset_length) else $error("soft reset length wrong"); // R04

    property p_soft_start;
        soft_start |=> soft_busy && ctrl == strap_ctrl;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft reset did not start"); // R04

    property p_kept_survives;
        soft_busy |=> gen_reg[3] == $past(gen_reg[3]) && gen_reg[0] == pmc_pkg::GEN_RESET_VALUE;
    endproperty
    a_kept_survives: assert property (p_kept_survives) else $error("kept field not kept"); // R03

    property p_loopback_write;
        wr_ctrl && !defaults_load |-> ##2 mode.loopback == $past(mgmt_req.wdata[14], 2);
    endproperty
    a_loopback_write: assert property (p_loopback_write) else $error("loopback not applied"); // R06

    property p_speed_select;
        1 |=> mode.speed_100 == ($past(ctrl[12]) ? $past(aneg_speed) : $past(ctrl[13]));
    endproperty
    a_speed_select: assert property (p_speed_select) else $error("speed selection wrong"); // R07

    property p_duplex_select;
        1 |=> mode.full_duplex == ($past(ctrl[12]) ? $past(aneg_full) : $past(ctrl[8]));
    endproperty
    a_duplex_select: assert property (p_duplex_select) else $error("duplex selection wrong"); // R13

    property p_restart_clears;
        ctrl[pmc_pkg::CTL_ANEG_RESTART] && !wr_ctrl |=> !ctrl[pmc_pkg::CTL_ANEG_RESTART];
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart bit stuck"); // R12

    property p_strap_default;
        $fell(strap_pending) |-> ctrl[13] == $past(strap_sync) && ctrl[12] == $past(strap_sync);
    endproperty
    a_strap_default: assert property (p_strap_default) else $error("strap default wrong"); // R09

    property p_reserved_zero;
        mgmt_req.rd && mgmt_req.index == pmc_pkg::IDX_BASIC_CONTROL
            |=> (mgmt_rsp.rdata & ~pmc_pkg::CTL_READ_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R16

    property p_status_done;
        rd_status |=> mgmt_rsp.ack && mgmt_rsp.rdata[5] == $past(aneg_done);
    endproperty
    a_status_done: assert property (p_status_done) else $error("status bit 5 wrong"); // R15

    property p_unmapped_zero;
        mgmt_req.rd && !idx_mapped |=> mgmt_rsp.rdata == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // R01

    property p_cov_soft;
        soft_start ##1 soft_busy;
    endproperty
    c_cov_soft: cover property (p_cov_soft);

    property p_cov_aneg;
        $rose(aneg_done);
    endproperty
    c_cov_aneg: cover property (p_cov_aneg);

    property p_cov_link_read;
        rd_status && !link_latched && link_sync;
    endproperty
    c_cov_link_read: cover property (p_cov_link_read);
endmodule

// ### pmc_pkg.sv
// constants, types and register map of the transceiver management register set
package pmc_pkg;
    localparam int REG_W = 16;
    localparam int IDX_W = 5;

    // register indices
    localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
    localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
    localparam logic [4:0] IDX_IDENT_LOW = 5'h03;
    localparam logic [4:0] IDX_NEG_ADVERTISE = 5'h04;
    localparam logic [4:0] IDX_NEG_PARTNER = 5'h05;
    localparam logic [4:0] IDX_NEG_EXPANSION = 5'h06;
    localparam logic [4:0] IDX_MODE_CONTROL = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_IND = 5'h1b;
    localparam logic [4:0] IDX_INT_SOURCE = 5'h1d;
    localparam logic [4:0] IDX_INT_MASK = 5'h1e;
    localparam logic [4:0] IDX_SPECIAL_CTRL = 5'h1f;

    // basic control fields
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED = 13;
    localparam int CTL_ANEG_EN = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_ANEG_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COL_TEST = 7;
    localparam logic [15:0] CTL_WRITE_MASK = 16'h7b80;
    localparam logic [15:0] CTL_READ_MASK = 16'hfb80;
    localparam logic [15:0] CTL_RESET_VALUE = 16'h0000;
    localparam logic [15:0] CTL_STRAP_MASK = 16'h3000;

    // basic status fields
    localparam int STS_ANEG_DONE = 5;
    localparam int STS_LINK = 2;
    localparam logic [15:0] STS_FIXED = 16'h7809;

    // advertisement
    localparam logic [15:0] ADV_WRITE_MASK = 16'h2dff;
    localparam logic [15:0] ADV_RESET_BASE = 16'h00a1;
    localparam logic [15:0] ADV_STRAP_BITS = 16'h0140;
    localparam int ADV_100_FULL = 8;
    localparam int ADV_100_HALF = 7;
    localparam int ADV_10_FULL = 6;

    // plain read/write registers, some kept through soft reset
    localparam int GEN_COUNT = 5;
    localparam logic [4:0] GEN_INDEX [GEN_COUNT] = '{5'h11, 5'h12, 5'h1b, 5'h1e, 5'h1f};
    localparam logic [GEN_COUNT-1:0] GEN_KEPT = 5'b0_1010;
    localparam logic [15:0] GEN_RESET_VALUE = 16'h0000;

    // timing
    localparam int SYS_CLK_MHZ = 200;
    localparam int SOFT_RESET_NS = 100;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SOFT_CNT_W = 5;
    localparam int ANEG_TIME_MS = 1500;
    localparam int ANEG_CYCLES_DEFAULT = ANEG_TIME_MS * SYS_CLK_MHZ * 1000;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ANEG_OFF,
        ANEG_BUSY,
        ANEG_DONE
    } pmc_aneg_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] index;
        logic [15:0] wdata;
    } pmc_mgmt_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } pmc_mgmt_rsp_t;

    typedef struct packed {
        logic loopback;
        logic power_down;
        logic speed_100;
        logic full_duplex;
        logic collision_test;
        logic soft_reset_busy;
        logic aneg_complete;
    } pmc_mode_t;
endpackage

// ### pmc_pin_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/100ps
module pmc_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic settled
);
    logic [1:0] settle_cnt;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge sys_clk) begin
                s1 <= pin_in[i];
                s2 <= s1;
                s3 <= s2;
            end
            // a change counts only once stages two and three agree
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    pin_out[i] <= 1'b0;
                end else if (s2 == s3) begin
                    pin_out[i] <= s3;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            settle_cnt <= 2'h0;
        end else if (settle_cnt != 2'(pmc_pkg::SYNC_STAGES)) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    assign settled = (settle_cnt == 2'(pmc_pkg::SYNC_STAGES));
endmodule

// ### pmc_aneg_sequencer.sv
// auto-negotiation progress timer and result selection
`timescale 1ns/100ps
module pmc_aneg_sequencer #(
    parameter int ANEG_CYCLES = pmc_pkg::ANEG_CYCLES_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic power_down,
    input wire logic restart,
    input wire logic [15:0] advertise,
    output logic complete,
    output logic res_speed_100,
    output logic res_full_duplex
);
    pmc_pkg::pmc_aneg_state_t state;
    pmc_pkg::pmc_aneg_state_t next_state;
    logic [31:0] cnt;
    logic active;
    logic timer_done;

    assign active = enable && !power_down;
    assign timer_done = (cnt == 32'(ANEG_CYCLES - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            pmc_pkg::ANEG_OFF: begin
                if (active) begin
                    next_state = pmc_pkg::ANEG_BUSY;
                end
            end
            pmc_pkg::ANEG_BUSY: begin
                if (!active) begin
                    next_state = pmc_pkg::ANEG_OFF;
                end else if (!restart && timer_done) begin
                    next_state = pmc_pkg::ANEG_DONE;
                end
            end
            pmc_pkg::ANEG_DONE: begin
                if (!active) begin
                    next_state = pmc_pkg::ANEG_OFF;
                end else if (restart) begin
                    next_state = pmc_pkg::ANEG_BUSY;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= pmc_pkg::ANEG_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || state != pmc_pkg::ANEG_BUSY || restart) begin
            cnt <= 32'h0000_0000;
        end else begin
            cnt <= cnt + 32'h0000_0001;
        end
    end

    // best common mode taken from our own advertisement
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            res_speed_100 <= 1'b0;
            res_full_duplex <= 1'b0;
        end else if (state == pmc_pkg::ANEG_BUSY && next_state == pmc_pkg::ANEG_DONE) begin
            res_speed_100 <= advertise[pmc_pkg::ADV_100_FULL] || advertise[pmc_pkg::ADV_100_HALF];
            res_full_duplex <= advertise[pmc_pkg::ADV_100_FULL]
                || (!advertise[pmc_pkg::ADV_100_HALF] && advertise[pmc_pkg::ADV_10_FULL]);
        end
    end

    assign complete = (state == pmc_pkg::ANEG_DONE);
endmodule

// ### pmc_mgmt_master.sv
// management access master model standing in for the mac side
`timescale 1ns/100ps
module pmc_mgmt_master (
    input wire logic sys_clk,
    output pmc_pkg::pmc_mgmt_req_t mgmt_req,
    input wire pmc_pkg::pmc_mgmt_rsp_t mgmt_rsp
);
    initial begin
        mgmt_req = '0;
    end

    // one indexed access, a single-cycle request, then a bounded wait for ack
    task automatic access(input logic wr, input logic [4:0] index, input logic [15:0] wdata,
                          output logic [15:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 16'h0000;
        @(negedge sys_clk);
        mgmt_req = '{wr: wr, rd: !wr, index: index, wdata: wdata};
        @(negedge sys_clk);
        mgmt_req.wr = 1'b0;
        mgmt_req.rd = 1'b0;
        // released lines show the inverse, not the last value
        mgmt_req.index = ~index;
        mgmt_req.wdata = ~wdata;
        for (n = 0; n < 4 && !ok; n++) begin
            if (mgmt_rsp.ack === 1'b1) begin
                ok = 1'b1;
                rdata = mgmt_rsp.rdata;
            end else begin
                @(negedge sys_clk);
            end
        end
    endtask
endmodule

// ### tb_top.sv
// self-checking bench of the management register set
`timescale 1ns/100ps
`define CHECK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin failures++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    localparam int ANEG_N = 50;
    // identity values are arbitrary
    localparam logic [15:0] ID_HI = 16'h0abc;
    localparam logic [15:0] ID_LO = 16'h0def;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic speed_sel_pin = 1'b1;
    logic link_up_pin = 1'b1;
    pmc_pkg::pmc_mgmt_req_t mgmt_req;
    pmc_pkg::pmc_mgmt_rsp_t mgmt_rsp;
    pmc_pkg::pmc_mode_t mode;
    int failures = 0;
    int n_tests = 0;

    always #2.5 sys_clk = ~sys_clk;

    pmc_mgmt_master pmc_mgmt_master_i (
        .sys_clk(sys_clk),
        .mgmt_req(mgmt_req),
        .mgmt_rsp(mgmt_rsp)
    );

    pmc_control_regs #(
        .ANEG_CYCLES(ANEG_N),
        .IDENT_HIGH(ID_HI),
        .IDENT_LOW(ID_LO)
    ) pmc_control_regs_i (
        .sys_clk(sys_clk),
        .reset(reset),
        .mgmt_req(mgmt_req),
        .mgmt_rsp(mgmt_rsp),
        .speed_sel_pin(speed_sel_pin),
        .link_up_pin(link_up_pin),
        .mode(mode)
    );

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                       output logic [15:0] rdat);
        logic ok;
        pmc_mgmt_master_i.access(wr, idx, wd, rdat, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR ack expected 1 seen 0");
            tally_and_finish();
        end
    endtask

    task automatic wr_reg(input logic [4:0] idx, input logic [15:0] wd);
        logic [15:0] d;
        acc(1'b1, idx, wd, d);
    endtask

    task automatic rd_reg(input logic [4:0] idx, output logic [15:0] d);
        acc(1'b0, idx, 16'h0000, d);
    endtask

    // waits for negotiation complete to reach val
    task automatic wait_aneg(input logic val);
        int n;
        for (n = 0; n < 4 * ANEG_N && mode.aneg_complete !== val; n++) begin
            @(negedge sys_clk);
        end
        if (mode.aneg_complete !== val) begin
            failures++;
            $display("ERROR aneg wait expected %b seen %b", val, mode.aneg_complete);
            tally_and_finish();
        end
    endtask

    task automatic do_reset(input logic strap);
        @(negedge sys_clk);
        reset = 1'b1;
        speed_sel_pin = strap;
        repeat (20) @(negedge sys_clk);
        reset = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask

    task automatic s_reset_map;
        logic [15:0] d;
        int i;
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("ctl reset", pmc_pkg::CTL_STRAP_MASK, d);
        rd_reg(pmc_pkg::IDX_IDENT_HIGH, d);
        `CHECK("ident high", ID_HI, d);
        rd_reg(pmc_pkg::IDX_IDENT_LOW, d);
        `CHECK("ident low", ID_LO, d);
        rd_reg(pmc_pkg::IDX_NEG_ADVERTISE, d);
        `CHECK("adv reset", pmc_pkg::ADV_RESET_BASE | pmc_pkg::ADV_STRAP_BITS, d);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("status fixed", pmc_pkg::STS_FIXED, d & 16'hffdb);
        rd_reg(5'h07, d);
        `CHECK("unmapped", 16'h0000, d);
        wr_reg(pmc_pkg::IDX_INT_SOURCE, 16'hffff);
        rd_reg(pmc_pkg::IDX_INT_SOURCE, d);
        `CHECK("int source", 16'h0000, d);
        for (i = 0; i < pmc_pkg::GEN_COUNT; i++) begin
            rd_reg(pmc_pkg::GEN_INDEX[i], d);
            `CHECK("plain reset", pmc_pkg::GEN_RESET_VALUE, d);
            wr_reg(pmc_pkg::GEN_INDEX[i], 16'h1100 + 16'(i));
            rd_reg(pmc_pkg::GEN_INDEX[i], d);
            `CHECK("plain rw", 16'h1100 + 16'(i), d);
        end
    endtask

    task automatic s_manual;
        logic [15:0] d;
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h6180);
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("ctl manual", 16'h6180, d);
        `CHECK("loopback", 1'b1, mode.loopback);
        `CHECK("speed 100", 1'b1, mode.speed_100);
        `CHECK("full duplex", 1'b1, mode.full_duplex);
        `CHECK("col test", 1'b1, mode.collision_test);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h4c7f);
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("ctl reserved", 16'h4800, d);
        `CHECK("power down", 1'b1, mode.power_down);
        `CHECK("speed 10", 1'b0, mode.speed_100);
        `CHECK("half duplex", 1'b0, mode.full_duplex);
        `CHECK("col test off", 1'b0, mode.collision_test);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h0000);
    endtask

    task automatic s_aneg;
        logic [15:0] d;
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h1000);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("aneg busy", 1'b0, d[5]);
        wait_aneg(1'b1);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("aneg done", 1'b1, d[5]);
        // strap high advertises 100 full, manual bits 13 and 8 are clear
        `CHECK("aneg speed", 1'b1, mode.speed_100);
        `CHECK("aneg duplex", 1'b1, mode.full_duplex);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h1200);
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("restart clears", 16'h1000, d);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("restarted", 1'b0, d[5]);
        wait_aneg(1'b1);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h1800);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("pd stops aneg", 1'b0, d[5]);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h1000);
        wait_aneg(1'b1);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("aneg after pd", 1'b1, d[5]);
        wr_reg(pmc_pkg::IDX_NEG_ADVERTISE, 16'h0061);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h1200);
        rd_reg(pmc_pkg::IDX_BASIC_STATUS, d);
        `CHECK("renegotiating", 1'b0, d[5]);
        wait_aneg(1'b1);
        // only 10 full advertised now
        `CHECK("aneg speed 10", 1'b0, mode.speed_100);
        `CHECK("aneg full 10", 1'b1, mode.full_duplex);
    endtask

    task automatic s_soft;
        logic [15:0] d;
        int i;
        int n;
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h4000);
        wr_reg(pmc_pkg::IDX_BASIC_CONTROL, 16'h8000);
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("soft busy", 1'b1, d[15]);
        for (n = 0; n < 100 && mode.soft_reset_busy !== 1'b0; n++) begin
            @(negedge sys_clk);
        end
        `CHECK("soft ends", 1'b0, mode.soft_reset_busy);
        if (mode.soft_reset_busy !== 1'b0) begin
            tally_and_finish();
        end
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("ctl after soft", pmc_pkg::CTL_STRAP_MASK, d);
        rd_reg(pmc_pkg::IDX_NEG_ADVERTISE, d);
        `CHECK("adv after soft", pmc_pkg::ADV_RESET_BASE | pmc_pkg::ADV_STRAP_BITS, d);
        for (i = 0; i < pmc_pkg::GEN_COUNT; i++) begin
            rd_reg(pmc_pkg::GEN_INDEX[i], d);
            `CHECK("kept", pmc_pkg::GEN_KEPT[i] ? 16'h1100 + 16'(i) : 16'h0000, d);
        end
        do_reset(1'b0);
        rd_reg(pmc_pkg::IDX_SPECIAL_MODES, d);
        `CHECK("hard clears", 16'h0000, d);
        rd_reg(pmc_pkg::IDX_BASIC_CONTROL, d);
        `CHECK("strap low", 16'h0000, d);
    endtask

    initial begin
        do_reset(1'b1);
        s_reset_map();
        s_manual();
        s_aneg();
        s_soft();
        tally_and_finish();
    end
endmodule
